//--- shared/pmrc_defines.svh
// Constants for the power mode and reset controller
`ifndef PMRC_DEFINES_SVH
`define PMRC_DEFINES_SVH
`define PMRC_CLK_PERIOD_NS 50
`define PMRC_RST_MIN_NS 50
`define PMRC_RST_MIN_CYC ((`PMRC_RST_MIN_NS + `PMRC_CLK_PERIOD_NS - 1) / `PMRC_CLK_PERIOD_NS)
`define PMRC_NUM_PERIPH 16
`define PMRC_NUM_WAKE 6
`define PMRC_NUM_RET 4
`define PMRC_BOOT_ADDR 32'h0000_0000
`define PMRC_RESET_HOLD 4'h8
`define PMRC_WAKE_PIN 0
`define PMRC_WAKE_WDT 1
`define PMRC_WAKE_USART 2
`define PMRC_WAKE_SPI 3
`define PMRC_WAKE_I2C 4
`define PMRC_WAKE_TIMER 5
`endif

//--- shared/pmrc_pkg.sv
// Types for the power mode and reset controller
package pmrc_pkg;
    typedef enum logic [1:0] {
        PMRC_MODE_SLEEP,
        PMRC_MODE_DEEP_SLEEP,
        PMRC_MODE_POWER_DOWN,
        PMRC_MODE_DEEP_PD
    } pmrc_mode_t;
    typedef enum logic [2:0] {
        PMRC_ST_RESET,
        PMRC_ST_RUN,
        PMRC_ST_SLEEP,
        PMRC_ST_DEEP_SLEEP,
        PMRC_ST_POWER_DOWN,
        PMRC_ST_DEEP_PD
    } pmrc_state_t;
    typedef struct packed {
        logic core_clk_en;
        logic irc_out_en;
        logic crystal_osc_en;
        logic pll_en;
        logic analog_en;
        logic flash_active;
        logic flash_standby;
        logic main_power_en;
    } pmrc_power_t;
    typedef struct packed {
        logic pin;
        logic wdt;
        logic por;
        logic brownout_detector;
    } pmrc_rst_src_t;
endpackage : pmrc_pkg

//--- tb/pmrc_pins.sv
// Model of the external reset and wake pins, both pulled up off chip
`timescale 1ns/1ns
module pmrc_pins (
    input wire logic ref_clk,
    output logic reset_pin_n,
    output logic wake_pin_n
);
    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Pull-ups hold both pins high while nothing drives them
    initial begin
        reset_pin_n = 1'b1;
        wake_pin_n = 1'b1;
    end
    task automatic pulse_rst(input int n);
        @(negedge ref_clk);
        reset_pin_n = 1'b0;
        repeat (n) @(negedge ref_clk);
        reset_pin_n = 1'b1;
    endtask : pulse_rst
    task automatic pulse_wake(input int n);
        @(negedge ref_clk);
        wake_pin_n = 1'b0;
        repeat (n) @(negedge ref_clk);
        wake_pin_n = 1'b1;
    endtask : pulse_wake
endmodule : pmrc_pins

//--- tb/tb.sv
// Self-checking testbench for the power mode and reset controller
`timescale 1ns/1ns
`include "pmrc_defines.svh"
module tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic ref_clk = 1'b0, arst_n = 1'b0, wdt_reset = 1'b0, por_n = 1'b1, wfi = 1'b0;
    logic dpd_lock = 1'b0, any_irq = 1'b0, lp_osc_sel = 1'b1, wdt_osc_sel = 1'b0;
    logic timer_wr = 1'b0, ret_wr = 1'b0;
    logic [3:0] bod_level = 4'h0;
    logic [1:0] bod_irq_sel = 2'h0, bod_rst_sel = 2'h3, mode_sel = 2'h0, ret_idx = 2'h0;
    logic [`PMRC_NUM_PERIPH-1:0] periph_clk_en = 16'h0000;
    logic [`PMRC_NUM_WAKE-1:0] wake_irq = 6'h00, wake_en = 6'h00, irq_ctrl_en = 6'h00;
    logic [31:0] timer_wdata = 32'h0, ret_wdata = 32'h0;
    logic reset_pin_n, wake_pin_n, chip_rst_n, flash_init, lp_osc_en, wdt_osc_en;
    logic bod_irq, bod_status, timer_timeout;
    logic [31:0] boot_addr, timer_count, ret_rdata;
    logic [`PMRC_NUM_PERIPH-1:0] periph_clk;
    pmrc_pkg::pmrc_power_t power;
    pmrc_pkg::pmrc_state_t state;
    int fails = 0, checks = 0;

    always #25 ref_clk = ~ref_clk;

    pmrc_pins pins (.ref_clk, .reset_pin_n, .wake_pin_n);
    pmrc_ctrl DUT (.ref_clk, .arst_n, .reset_pin_n, .wdt_reset, .por_n, .bod_level,
        .bod_irq_sel, .bod_rst_sel, .mode_sel, .wfi, .dpd_lock, .periph_clk_en, .wake_irq,
        .wake_en, .irq_ctrl_en, .any_irq, .lp_osc_sel, .wdt_osc_sel, .wake_pin_n, .timer_wr,
        .timer_wdata, .ret_wr, .ret_idx, .ret_wdata, .chip_rst_n, .flash_init, .boot_addr,
        .power, .periph_clk, .lp_osc_en, .wdt_osc_en, .bod_irq, .bod_status, .timer_count,
        .timer_timeout, .ret_rdata, .state);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", n, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc

    task automatic wait_st(input pmrc_pkg::pmrc_state_t s);
        for (int i = 0; i < 40 && state !== s; i++) @(negedge ref_clk);
        chk("state", state, s);
    endtask : wait_st

    task automatic enter(input logic [1:0] m);
        mode_sel = m;
        wfi = 1'b1;
        @(negedge ref_clk);
        wfi = 1'b0;
    endtask : enter

    task automatic fin(input string n);
        $display("test %s ends", n);
    endtask : fin

    task automatic results;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_sleep;
        periph_clk_en = 16'hA5C3;
        cyc(2);
        chk("pclk", periph_clk, 16'hA5C3);
        enter(2'h0);
        chk("state", state, pmrc_pkg::PMRC_ST_SLEEP);
        chk("core", power.core_clk_en, 1'b0);
        chk("pclk", periph_clk, 16'hA5C3);
        cyc(3);
        chk("state", state, pmrc_pkg::PMRC_ST_SLEEP);
        any_irq = 1'b1;
        wait_st(pmrc_pkg::PMRC_ST_RUN);
        any_irq = 1'b0;
        chk("core", power.core_clk_en, 1'b1);
        dpd_lock = 1'b1;
        enter(2'h3);
        chk("state", state, pmrc_pkg::PMRC_ST_SLEEP);
        any_irq = 1'b1;
        wait_st(pmrc_pkg::PMRC_ST_RUN);
        any_irq = 1'b0;
        dpd_lock = 1'b0;
        fin("sleep");
    endtask : t_sleep

    task automatic t_wake;
        pmrc_pkg::pmrc_state_t st;
        for (int m = 1; m < 3; m++) begin
            st = (m == 1) ? pmrc_pkg::PMRC_ST_DEEP_SLEEP : pmrc_pkg::PMRC_ST_POWER_DOWN;
            for (int s = 0; s < 5; s++) begin
                wake_en = 6'h01 << s;
                irq_ctrl_en = 6'h00;
                wdt_osc_sel = s[0];
                enter(2'(m));
                chk("state", state, st);
                chk("pclk", periph_clk, 16'h0000);
                chk("irc", power.irc_out_en, 1'b0);
                chk("xosc", power.crystal_osc_en, 1'b0);
                chk("ana", power.analog_en, 1'b0);
                chk("fsb", power.flash_standby, m == 1);
                chk("lp", lp_osc_en, 1'b1);
                chk("wd", wdt_osc_en, s[0]);
                chk("fact", power.flash_active, 1'b0);
                wake_irq = 6'h01 << s;
                cyc(3);
                chk("state", state, st);
                wake_en = 6'h00;
                irq_ctrl_en = 6'h01 << s;
                cyc(3);
                chk("state", state, st);
                wake_en = 6'h01 << s;
                wait_st(pmrc_pkg::PMRC_ST_RUN);
                wake_irq = 6'h00;
            end
        end
        fin("wake");
    endtask : t_wake

    task automatic t_dpd;
        for (int i = 0; i < 4; i++) begin
            ret_idx = 2'(i);
            ret_wdata = 32'hC0DE_0000 + 32'(i);
            ret_wr = 1'b1;
            cyc(1);
        end
        ret_wr = 1'b0;
        wdt_osc_sel = 1'b1;
        enter(2'h3);
        chk("state", state, pmrc_pkg::PMRC_ST_DEEP_PD);
        chk("main", power.main_power_en, 1'b0);
        chk("wd", wdt_osc_en, 1'b0);
        cyc(3);
        chk("state", state, pmrc_pkg::PMRC_ST_DEEP_PD);
        pins.pulse_wake(3);
        wait_st(pmrc_pkg::PMRC_ST_RUN);
        for (int i = 0; i < 4; i++) begin
            ret_idx = 2'(i);
            cyc(1);
            chk("ret", ret_rdata, 32'hC0DE_0000 + 32'(i));
        end
        timer_wdata = 32'h0000_0014;
        timer_wr = 1'b1;
        cyc(1);
        timer_wr = 1'b0;
        chk("tcnt", timer_count, 32'h0000_0014);
        enter(2'h3);
        chk("tcnt", timer_count, 32'h0000_0013);
        chk("state", state, pmrc_pkg::PMRC_ST_DEEP_PD);
        for (int i = 0; i < 40 && timer_timeout !== 1'b1; i++) @(negedge ref_clk);
        chk("tout", timer_timeout, 1'b1);
        wait_st(pmrc_pkg::PMRC_ST_RUN);
        fin("deep_pd");
    endtask : t_dpd

    task automatic t_bod;
        for (int l = 0; l < 4; l++) begin
            bod_irq_sel = 2'(l);
            bod_rst_sel = 2'(l) ^ 2'h2;
            bod_level = 4'h1 << l;
            cyc(3);
            chk("birq", bod_irq, 1'b1);
            chk("bst", bod_status, 1'b1);
            chk("rst", chip_rst_n, 1'b1);
            bod_irq_sel = 2'(l) ^ 2'h1;
            cyc(3);
            chk("birq", bod_irq, 1'b0);
        end
        bod_level = 4'h0;
        fin("bod");
    endtask : t_bod

    task automatic t_rst;
        for (int k = 0; k < 7; k++) begin
            case (k)
                0: pins.pulse_rst(1);
                1: wdt_reset = 1'b1;
                2: por_n = 1'b0;
                default: begin
                    bod_rst_sel = 2'(k - 3);
                    bod_level = 4'h1 << (k - 3);
                end
            endcase
            for (int i = 0; i < 10 && chip_rst_n !== 1'b0; i++) @(negedge ref_clk);
            chk("rst", chip_rst_n, 1'b0);
            chk("finit", flash_init, 1'b1);
            cyc(1);
            chk("state", state, pmrc_pkg::PMRC_ST_RESET);
            wdt_reset = 1'b0;
            por_n = 1'b1;
            bod_level = 4'h0;
            wait_st(pmrc_pkg::PMRC_ST_RUN);
            chk("rst", chip_rst_n, 1'b1);
            chk("boot", boot_addr, 32'h0000_0000);
            chk("irc", power.irc_out_en, 1'b1);
            chk("pll", power.pll_en, 1'b0);
        end
        fin("reset_src");
    endtask : t_rst

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        cyc(16);
        chk("rst", chip_rst_n, 1'b0);
        chk("finit", flash_init, 1'b1);
        arst_n = 1'b1;
        wait_st(pmrc_pkg::PMRC_ST_RUN);
        chk("boot", boot_addr, 32'h0000_0000);
        chk("irc", power.irc_out_en, 1'b1);
        chk("xosc", power.crystal_osc_en, 1'b0);
        // Software never starts crystal or PLL here, so both stay off
        chk("pll", power.pll_en, 1'b0);
        fin("power_up");
        t_sleep();
        t_wake();
        t_dpd();
        t_bod();
        t_rst();
        results();
    end

    initial begin
        repeat (4000) @(posedge ref_clk);
        fails++;
        results();
    end
endmodule : tb

//--- verilog/pmrc_ctrl.sv
// Power mode, wake-up and reset controller
`timescale 1ns/1ns
`include "pmrc_defines.svh"
module pmrc_ctrl (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic reset_pin_n,
    input wire logic wdt_reset,
    input wire logic por_n,
    input wire logic [3:0] bod_level,
    input wire logic [1:0] bod_irq_sel,
    input wire logic [1:0] bod_rst_sel,
    input wire logic [1:0] mode_sel,
    input wire logic wfi,
    input wire logic dpd_lock,
    input wire logic [`PMRC_NUM_PERIPH-1:0] periph_clk_en,
    input wire logic [`PMRC_NUM_WAKE-1:0] wake_irq,
    input wire logic [`PMRC_NUM_WAKE-1:0] wake_en,
    input wire logic [`PMRC_NUM_WAKE-1:0] irq_ctrl_en,
    input wire logic any_irq,
    input wire logic lp_osc_sel,
    input wire logic wdt_osc_sel,
    input wire logic wake_pin_n,
    input wire logic timer_wr,
    input wire logic [31:0] timer_wdata,
    input wire logic ret_wr,
    input wire logic [1:0] ret_idx,
    input wire logic [31:0] ret_wdata,
    output logic chip_rst_n,
    output logic flash_init,
    output logic [31:0] boot_addr,
    output pmrc_pkg::pmrc_power_t power,
    output logic [`PMRC_NUM_PERIPH-1:0] periph_clk,
    output logic lp_osc_en,
    output logic wdt_osc_en,
    output logic bod_irq,
    output logic bod_status,
    output logic [31:0] timer_count,
    output logic timer_timeout,
    output logic [31:0] ret_rdata,
    output pmrc_pkg::pmrc_state_t state
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] s1_q;
    logic [2:0] s2_q;
    logic [3:0] b1_q;
    logic [3:0] b2_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
            b1_q <= 4'h0;
            b2_q <= 4'h0;
        end else begin
            s1_q <= {reset_pin_n, por_n, wake_pin_n};
            s2_q <= s1_q;
            b1_q <= bod_level;
            b2_q <= b1_q;
        end
    end
    logic pin_n_s;
    logic por_n_s;
    logic wake_n_s;
    assign pin_n_s = s2_q[2];
    assign por_n_s = s2_q[1];
    assign wake_n_s = s2_q[0];

    // ------------------------------------------------------------
    // Reset merge and stretch
    // ------------------------------------------------------------
    function automatic logic bod_hit(input logic [3:0] lv, input logic [1:0] sel);
        bod_hit = lv[sel];
    endfunction : bod_hit

    pmrc_pkg::pmrc_rst_src_t src;
    logic any_rst;
    logic [3:0] hold_q;
    logic [3:0] hold_d;
    logic rst_n_q;
    logic rst_n_d;
    logic finit_q;
    logic finit_d;
    always_comb begin
        src.pin = ~pin_n_s;
        src.wdt = wdt_reset;
        src.por = ~por_n_s;
        src.brownout_detector = bod_hit(b2_q, bod_rst_sel);
        any_rst = |src;
        hold_d = hold_q;
        rst_n_d = rst_n_q;
        finit_d = 1'b0;
        if (any_rst) begin
            hold_d = `PMRC_RESET_HOLD;
            rst_n_d = 1'b0;
            finit_d = 1'b1;
        end else if (hold_q != 4'h0) begin
            hold_d = hold_q - 4'h1;
        end else begin
            rst_n_d = 1'b1;
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_q <= `PMRC_RESET_HOLD;
            rst_n_q <= 1'b0;
            finit_q <= 1'b1;
        end else begin
            hold_q <= hold_d;
            rst_n_q <= rst_n_d;
            finit_q <= finit_d;
        end
    end

    // ------------------------------------------------------------
    // Self-wake timer and retention registers
    // ------------------------------------------------------------
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic run_q;
    logic run_d;
    logic to_q;
    logic to_d;
    logic [31:0] ret_q [`PMRC_NUM_RET];
    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        to_d = 1'b0;
        if (timer_wr) begin
            cnt_d = timer_wdata;
            run_d = (timer_wdata != 32'h0000_0000);
        end else if (run_q) begin
            cnt_d = cnt_q - 32'h0000_0001;
            if (cnt_q == 32'h0000_0001) begin
                run_d = 1'b0;
                to_d = 1'b1;
            end
        end
    end
    // Timer and retention survive chip reset (always-on domain)
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 32'h0000_0000;
            run_q <= 1'b0;
            to_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            run_q <= run_d;
            to_q <= to_d;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < `PMRC_NUM_RET; gi++) begin : g_ret
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    ret_q[gi] <= 32'h0000_0000;
                end else if (ret_wr && ret_idx == 2'(gi)) begin
                    ret_q[gi] <= ret_wdata;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    pmrc_pkg::pmrc_state_t st_q;
    pmrc_pkg::pmrc_state_t st_d;
    logic wake_ok;
    logic [`PMRC_NUM_WAKE-1:0] wk;
    always_comb begin
        wk = wake_irq;
        wk[`PMRC_WAKE_TIMER] = wake_irq[`PMRC_WAKE_TIMER] | to_q;
        wake_ok = |(wk & wake_en & irq_ctrl_en);
        st_d = st_q;
        case (st_q)
            pmrc_pkg::PMRC_ST_RESET: begin
                if (rst_n_q) begin
                    st_d = pmrc_pkg::PMRC_ST_RUN;
                end
            end
            pmrc_pkg::PMRC_ST_RUN: begin
                if (wfi) begin
                    case (pmrc_pkg::pmrc_mode_t'(mode_sel))
                        pmrc_pkg::PMRC_MODE_SLEEP: st_d = pmrc_pkg::PMRC_ST_SLEEP;
                        pmrc_pkg::PMRC_MODE_DEEP_SLEEP: st_d = pmrc_pkg::PMRC_ST_DEEP_SLEEP;
                        pmrc_pkg::PMRC_MODE_POWER_DOWN: st_d = pmrc_pkg::PMRC_ST_POWER_DOWN;
                        pmrc_pkg::PMRC_MODE_DEEP_PD: st_d = dpd_lock ? pmrc_pkg::PMRC_ST_SLEEP
                                                                      : pmrc_pkg::PMRC_ST_DEEP_PD;
                        default: st_d = pmrc_pkg::PMRC_ST_RUN;
                    endcase
                end
            end
            pmrc_pkg::PMRC_ST_SLEEP: begin
                if (any_irq) begin
                    st_d = pmrc_pkg::PMRC_ST_RUN;
                end
            end
            pmrc_pkg::PMRC_ST_DEEP_SLEEP, pmrc_pkg::PMRC_ST_POWER_DOWN: begin
                if (wake_ok) begin
                    st_d = pmrc_pkg::PMRC_ST_RUN;
                end
            end
            pmrc_pkg::PMRC_ST_DEEP_PD: begin
                if (!wake_n_s || to_q) begin
                    st_d = pmrc_pkg::PMRC_ST_RESET;
                end
            end
            default: st_d = pmrc_pkg::PMRC_ST_RESET;
        endcase
        if (!rst_n_q) begin
            st_d = pmrc_pkg::PMRC_ST_RESET;
        end
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= pmrc_pkg::PMRC_ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Power and clock controls
    // ------------------------------------------------------------
    pmrc_pkg::pmrc_power_t pw;
    logic [`PMRC_NUM_PERIPH-1:0] pclk;
    logic lp_en;
    logic wd_en;
    logic b_irq;
    always_comb begin
        pw = '{core_clk_en: 1'b1, irc_out_en: 1'b1, crystal_osc_en: 1'b0, pll_en: 1'b0,
               analog_en: 1'b1, flash_active: 1'b1, flash_standby: 1'b0, main_power_en: 1'b1};
        pclk = periph_clk_en;
        lp_en = lp_osc_sel;
        wd_en = wdt_osc_sel;
        case (st_d)
            pmrc_pkg::PMRC_ST_RESET: begin
                pw.core_clk_en = 1'b0;
                pclk = '0;
            end
            // Crystal and PLL left off for software to start
            pmrc_pkg::PMRC_ST_RUN: begin
                pw.core_clk_en = 1'b1;
            end
            pmrc_pkg::PMRC_ST_SLEEP: begin
                pw.core_clk_en = 1'b0;
            end
            pmrc_pkg::PMRC_ST_DEEP_SLEEP: begin
                pw.core_clk_en = 1'b0;
                pw.irc_out_en = 1'b0;
                pw.analog_en = 1'b0;
                pw.flash_active = 1'b0;
                pw.flash_standby = 1'b1;
                pclk = '0;
            end
            pmrc_pkg::PMRC_ST_POWER_DOWN: begin
                pw = '0;
                pclk = '0;
            end
            pmrc_pkg::PMRC_ST_DEEP_PD: begin
                pw = '0;
                pclk = '0;
                wd_en = 1'b0;
                lp_en = lp_osc_sel | run_q;
            end
            default: begin
                pw = '0;
                pclk = '0;
            end
        endcase
        b_irq = bod_hit(b2_q, bod_irq_sel);
    end
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            power <= '{core_clk_en: 1'b0, irc_out_en: 1'b1, crystal_osc_en: 1'b0, pll_en: 1'b0,
                       analog_en: 1'b1, flash_active: 1'b1, flash_standby: 1'b0,
                       main_power_en: 1'b1};
            periph_clk <= '0;
            lp_osc_en <= 1'b0;
            wdt_osc_en <= 1'b0;
            bod_irq <= 1'b0;
            bod_status <= 1'b0;
        end else begin
            power <= pw;
            periph_clk <= pclk;
            lp_osc_en <= lp_en;
            wdt_osc_en <= wd_en;
            bod_irq <= b_irq;
            bod_status <= b_irq;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            chip_rst_n <= 1'b0;
            flash_init <= 1'b1;
            boot_addr <= `PMRC_BOOT_ADDR;
            timer_count <= 32'h0000_0000;
            timer_timeout <= 1'b0;
            ret_rdata <= 32'h0000_0000;
            state <= pmrc_pkg::PMRC_ST_RESET;
        end else begin
            chip_rst_n <= rst_n_d;
            flash_init <= finit_d;
            boot_addr <= `PMRC_BOOT_ADDR;
            timer_count <= cnt_d;
            timer_timeout <= to_d;
            ret_rdata <= ret_q[ret_idx];
            state <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Locked deep power-down
    dpd_lock_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st_q == pmrc_pkg::PMRC_ST_RUN && wfi && dpd_lock && rst_n_q)
        |=> state != pmrc_pkg::PMRC_ST_DEEP_PD) else $error("deep power-down entered while locked");
    sleep_core_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state == pmrc_pkg::PMRC_ST_SLEEP |-> !power.core_clk_en && power.irc_out_en
        && power.flash_active && power.analog_en)
        else $error("sleep clock gating wrong");
    rst_merge_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wdt_reset |=> !chip_rst_n ##1 !chip_rst_n) else $error("watchdog reset missed");
    flash_init_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        wdt_reset |=> flash_init) else $error("flash init missing");
    deep_sleep_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state == pmrc_pkg::PMRC_ST_DEEP_SLEEP |-> periph_clk == '0 && !power.irc_out_en
        && power.flash_standby) else $error("deep-sleep gating wrong");
    pd_off_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        state == pmrc_pkg::PMRC_ST_POWER_DOWN |-> power == '0) else $error("power-down not off");
    timer_dec_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (run_q && !timer_wr && cnt_q > 32'h1) |=> cnt_q == $past(cnt_q) - 32'h1)
        else $error("timer did not count");
    wake_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st_q == pmrc_pkg::PMRC_ST_POWER_DOWN && rst_n_q && !wake_ok)
        |=> st_q == pmrc_pkg::PMRC_ST_POWER_DOWN) else $error("woke without enable");
endmodule : pmrc_ctrl
